// ===== src/port_pair_strap_params.svh
// constants for the port pair strap capture block
`ifndef PORT_PAIR_STRAP_PARAMS_SVH
`define PORT_PAIR_STRAP_PARAMS_SVH

`define CORE_CLK_PERIOD_NS   8
`define STRAP_HOLD_CYCLES    10
`define SAMPLE_CNT_W         4
`define ADDR_W               4
`define DATA_W               32
`define REG_CLKSEL_OFFSET    4'h0
`define REG_STATUS_OFFSET    4'h4
`define CLKSEL_PRI_PD_BIT    0
`define CLKSEL_SEC_PD_BIT    1
`define CLKSEL_PRI_OVR_BIT   2
`define CLKSEL_SEC_OVR_BIT   3
`define STAT_MODE_BIT        0
`define STAT_PRI_PD_BIT      1
`define STAT_SEC_PD_BIT      2
`define STAT_DONE_BIT        3
`define STAT_PORTN_PD_BIT    4
`define STAT_PORTN1_PD_BIT   5
`define CLKSEL_RESET         4'h0

`endif

// ===== src/port_pair_strap_pkg.sv
// types for the port pair strap capture block
package port_pair_strap_pkg;
    typedef enum logic [1:0] {
        CAP_RESET  = 2'b00,
        CAP_SAMPLE = 2'b01,
        CAP_DONE   = 2'b10
    } capture_state_t;
endpackage

// ===== src/strap_sync.sv
// two-flop synchroniser for the strap pins
`timescale 1ns/100ps
`default_nettype none
module strap_sync #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // raw and synchronised levels
    input  wire logic [WIDTH-1:0] rawIn,
    output logic      [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_r  <= '0;
            syncOut <= '0;
        end else begin
            meta_r  <= rawIn;
            syncOut <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ===== src/port_pair_strap_config.sv
// strap capture and power-down control for one serial port pair
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "port_pair_strap_params.svh"
module port_pair_strap_config #(
    parameter int PAIR_BASE = 0,
    parameter int HOLD_CYCLES = `STRAP_HOLD_CYCLES
) (
    // clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst,
    input  wire logic                hardResetLow,
    input  wire logic                testMode,
    // strap pins
    input  wire logic                pairLaneModeStrapIn,
    output logic                     pairLaneModeStrapOut,
    output logic                     pairLaneModeStrapOe,
    input  wire logic                primaryPortPowerDownStrapIn,
    output logic                     primaryPortPowerDownStrapOut,
    output logic                     primaryPortPowerDownStrapOe,
    input  wire logic                secondaryPortPowerDownStrapIn,
    output logic                     secondaryPortPowerDownStrapOut,
    output logic                     secondaryPortPowerDownStrapOe,
    input  wire logic [2:0]          testStrapDrive,
    // register port
    input  wire logic [`ADDR_W-1:0]  regAddr,
    input  wire logic [`DATA_W-1:0]  regWdata,
    input  wire logic                regWrite,
    input  wire logic                regRead,
    output logic      [`DATA_W-1:0]  regRdata,
    // pair configuration
    output logic                     pairSingleLane,
    output logic                     portNEnable,
    output logic                     portN1Enable,
    output logic      [3:0]          laneMacroPowerDown,
    output logic                     portNPowerDown,
    output logic                     portN1PowerDown,
    output logic                     strapsCaptured
);
    ////////////////////////////////////////////////////////////////////////
    // elaboration checks
    if (PAIR_BASE % 2 != 0 || PAIR_BASE < 0 || PAIR_BASE > 6) begin : gBadPairBase
        $error("pair base must be 0, 2, 4 or 6");
    end
    if (HOLD_CYCLES < 1 || HOLD_CYCLES > 15) begin : gBadHoldCycles
        $error("hold cycles must fit the sample counter");
    end

    ////////////////////////////////////////////////////////////////////////
    // synchronisers
    logic [2:0] strapSync;
    logic [1:0] hrstSyncPair;
    logic       hrstMeta_r;
    logic       hrstSync_r;
    logic       hrstPrev_r;

    strap_sync #(.WIDTH(3)) uStrapSync (
        .core_clk (core_clk),
        .rst      (rst),
        .rawIn    ({pairLaneModeStrapIn, primaryPortPowerDownStrapIn,
                    secondaryPortPowerDownStrapIn}),
        .syncOut  (strapSync)
    );

    // hard reset pin synchroniser and release edge history
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hrstMeta_r <= 1'b0;
            hrstSync_r <= 1'b0;
            hrstPrev_r <= 1'b0;
        end else begin
            hrstMeta_r <= hardResetLow;
            hrstSync_r <= hrstMeta_r;
            hrstPrev_r <= hrstSync_r;
        end
    end
    assign hrstSyncPair = {hrstPrev_r, hrstSync_r};

    logic inHardReset;
    assign inHardReset = ~hrstSync_r;

    ////////////////////////////////////////////////////////////////////////
    // capture sequencer
    port_pair_strap_pkg::capture_state_t state_r;
    port_pair_strap_pkg::capture_state_t state_nxt;
    logic [`SAMPLE_CNT_W-1:0]            sampleCnt_r;
    logic [`SAMPLE_CNT_W-1:0]            holdLast;
    assign holdLast = HOLD_CYCLES[`SAMPLE_CNT_W-1:0] - 4'h1;

    // next state: sample during the hold window, then freeze
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            port_pair_strap_pkg::CAP_RESET: begin
                if (hrstSyncPair == 2'b01) begin
                    state_nxt = port_pair_strap_pkg::CAP_SAMPLE;
                end
            end
            port_pair_strap_pkg::CAP_SAMPLE: begin
                if (inHardReset) begin
                    state_nxt = port_pair_strap_pkg::CAP_RESET;
                end else if (sampleCnt_r == holdLast) begin
                    state_nxt = port_pair_strap_pkg::CAP_DONE;
                end
            end
            port_pair_strap_pkg::CAP_DONE: begin
                if (inHardReset) begin
                    state_nxt = port_pair_strap_pkg::CAP_RESET;
                end
            end
            default: state_nxt = port_pair_strap_pkg::CAP_RESET;
        endcase
    end

    // state register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= port_pair_strap_pkg::CAP_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    // sample window counter
    always_ff @(posedge core_clk) begin
        if (rst || state_r != port_pair_strap_pkg::CAP_SAMPLE) begin
            sampleCnt_r <= '0;
        end else begin
            sampleCnt_r <= sampleCnt_r + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // captured straps
    logic modeCap_r;
    logic priPdCap_r;
    logic secPdCap_r;
    logic sampleFirst;

    // only the window's first cycle loads: later pin moves fall outside the board's hold time
    assign sampleFirst = (state_r == port_pair_strap_pkg::CAP_SAMPLE) && (sampleCnt_r == '0);

    // load once at the start of the window, hold afterwards
    always_ff @(posedge core_clk) begin
        if (rst) begin
            modeCap_r  <= 1'b0;
            priPdCap_r <= 1'b1;
            secPdCap_r <= 1'b1;
        end else if (sampleFirst) begin
            modeCap_r  <= strapSync[2];
            priPdCap_r <= strapSync[1];
            secPdCap_r <= strapSync[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock selection register
    logic [3:0] clkSel_r;
    logic       clkSelWr;
    assign clkSelWr = regWrite && (regAddr == `REG_CLKSEL_OFFSET);

    // software override fields, cleared by any hard reset
    always_ff @(posedge core_clk) begin
        if (rst || inHardReset) begin
            clkSel_r <= `CLKSEL_RESET;
        end else if (clkSelWr) begin
            clkSel_r <= regWdata[3:0];
        end
    end

    logic priPdEff;
    logic secPdEff;
    assign priPdEff = clkSel_r[`CLKSEL_PRI_OVR_BIT] ? clkSel_r[`CLKSEL_PRI_PD_BIT]
                                                    : priPdCap_r;
    assign secPdEff = clkSel_r[`CLKSEL_SEC_OVR_BIT] ? clkSel_r[`CLKSEL_SEC_PD_BIT]
                                                    : secPdCap_r;

    ////////////////////////////////////////////////////////////////////////
    // pair configuration outputs
    logic done;
    assign done = (state_r == port_pair_strap_pkg::CAP_DONE);

    // outputs held safe (powered down) until capture completes
    always_ff @(posedge core_clk) begin
        if (rst || !done) begin
            pairSingleLane     <= 1'b0;
            portNEnable        <= 1'b0;
            portN1Enable       <= 1'b0;
            portNPowerDown     <= 1'b1;
            portN1PowerDown    <= 1'b1;
            laneMacroPowerDown <= 4'hf;
        end else begin
            pairSingleLane     <= modeCap_r;
            portNEnable        <= ~priPdEff;
            portN1Enable       <= modeCap_r & ~priPdEff & ~secPdEff;
            portNPowerDown     <= priPdEff;
            portN1PowerDown    <= priPdEff | secPdEff;
            laneMacroPowerDown <= {4{priPdEff}};
        end
    end
    assign strapsCaptured = done;

    ////////////////////////////////////////////////////////////////////////
    // strap pin drivers, live only in test mode
    assign pairLaneModeStrapOe           = testMode;
    assign primaryPortPowerDownStrapOe   = testMode;
    assign secondaryPortPowerDownStrapOe = testMode;
    assign pairLaneModeStrapOut           = testStrapDrive[2];
    assign primaryPortPowerDownStrapOut   = testStrapDrive[1];
    assign secondaryPortPowerDownStrapOut = testStrapDrive[0];

    ////////////////////////////////////////////////////////////////////////
    // register read port
    logic [`DATA_W-1:0] status;
    always_comb begin
        status = '0;
        status[`STAT_MODE_BIT]      = modeCap_r;
        status[`STAT_PRI_PD_BIT]    = priPdCap_r;
        status[`STAT_SEC_PD_BIT]    = secPdCap_r;
        status[`STAT_DONE_BIT]      = done;
        status[`STAT_PORTN_PD_BIT]  = portNPowerDown;
        status[`STAT_PORTN1_PD_BIT] = portN1PowerDown;
    end

    // read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge core_clk) begin
        if (rst || !regRead) begin
            regRdata <= '0;
        end else begin
            case (regAddr)
                `REG_CLKSEL_OFFSET: regRdata <= {28'h0000000, clkSel_r};
                `REG_STATUS_OFFSET: regRdata <= status;
                default:            regRdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    // window length counted apart from the sequencer's own counter
    logic [4:0] windowLen_r;
    always_ff @(posedge core_clk) begin
        if (rst || state_r != port_pair_strap_pkg::CAP_SAMPLE) begin
            windowLen_r <= '0;
        end else if (windowLen_r != 5'h1f) begin
            windowLen_r <= windowLen_r + 5'h1;
        end
    end

    // capture window
    a_sample_window_len: assert property (@(posedge core_clk) disable iff (rst)
        state_r == port_pair_strap_pkg::CAP_DONE
        && $past(state_r) == port_pair_strap_pkg::CAP_SAMPLE
        |-> windowLen_r == HOLD_CYCLES)
        else $error("sampling window differs from the hold length");

    a_capture_first_cycle: assert property (@(posedge core_clk) disable iff (rst)
        sampleFirst |=> modeCap_r == $past(strapSync[2]) && priPdCap_r == $past(strapSync[1])
                        && secPdCap_r == $past(strapSync[0]))
        else $error("straps not taken at the first window cycle");

    a_late_pins_ignored: assert property (@(posedge core_clk) disable iff (rst)
        !sampleFirst |=> $stable(modeCap_r) && $stable(priPdCap_r) && $stable(secPdCap_r))
        else $error("captured strap moved outside the first window cycle");

    a_caps_frozen_done: assert property (@(posedge core_clk) disable iff (rst)
        done && $past(done) |-> $stable(modeCap_r) && $stable(priPdCap_r)
                                && $stable(secPdCap_r))
        else $error("captured strap changed after window");

    a_hard_reset_idle: assert property (@(posedge core_clk) disable iff (rst)
        $past(inHardReset) |-> state_r == port_pair_strap_pkg::CAP_RESET)
        else $error("capture not restarted by hard reset");

    // power and lane outputs
    a_safe_until_done: assert property (@(posedge core_clk) disable iff (rst)
        !$past(done) |-> portNPowerDown && portN1PowerDown && !portNEnable && !portN1Enable
                         && !pairSingleLane && laneMacroPowerDown == 4'hf)
        else $error("pair outputs left the safe state before capture");

    a_primary_down_both: assert property (@(posedge core_clk) disable iff (rst)
        done && $past(done) && $past(priPdEff) |-> portNPowerDown && portN1PowerDown)
        else $error("primary power-down did not stop both ports");

    a_primary_up_n: assert property (@(posedge core_clk) disable iff (rst)
        done && $past(done) && !$past(priPdEff) |-> !portNPowerDown
        && (portN1PowerDown == $past(secPdEff)))
        else $error("primary power-up mishandled");

    a_n_enable_follows: assert property (@(posedge core_clk) disable iff (rst)
        done && $past(done) |-> portNEnable == !$past(priPdEff)
                                && pairSingleLane == $past(modeCap_r))
        else $error("port n enable or lane mode off its source");

    a_n1_enable_follows: assert property (@(posedge core_clk) disable iff (rst)
        done && $past(done) |-> portN1Enable == ($past(modeCap_r) && !$past(priPdEff)
                                                 && !$past(secPdEff)))
        else $error("port n+1 enable off its source");

    a_lanes_together: assert property (@(posedge core_clk) disable iff (rst)
        laneMacroPowerDown == 4'h0 || laneMacroPowerDown == 4'hf)
        else $error("lanes powered down individually");

    a_four_lane_n1_off: assert property (@(posedge core_clk) disable iff (rst)
        done && $past(done) && !$past(modeCap_r) |-> !portN1Enable && !pairSingleLane)
        else $error("port n+1 available in four-lane mode");

    // software overrides, hard reset and status
    a_override_pri: assert property (@(posedge core_clk) disable iff (rst)
        clkSelWr && !inHardReset && regWdata[`CLKSEL_PRI_OVR_BIT] && done
        ##1 done |=> portNPowerDown == $past(regWdata[`CLKSEL_PRI_PD_BIT], 2))
        else $error("primary override not applied");

    a_override_sec: assert property (@(posedge core_clk) disable iff (rst)
        clkSelWr && !inHardReset && regWdata[`CLKSEL_SEC_OVR_BIT] && done
        && !priPdEff && !regWdata[`CLKSEL_PRI_OVR_BIT]
        ##1 done |=> portN1PowerDown == $past(regWdata[`CLKSEL_SEC_PD_BIT], 2))
        else $error("secondary override not applied");

    a_hard_reset_clears: assert property (@(posedge core_clk) disable iff (rst)
        $past(inHardReset) |-> clkSel_r == `CLKSEL_RESET)
        else $error("override fields survived a hard reset");

    a_status_read: assert property (@(posedge core_clk) disable iff (rst)
        $past(regRead) && !$past(rst) && $past(regAddr) == `REG_STATUS_OFFSET
        |-> regRdata[`STAT_MODE_BIT] == $past(modeCap_r)
            && regRdata[`STAT_DONE_BIT] == $past(done))
        else $error("status read does not show the captured mode");

    // strap pin drivers
    a_drivers_test_only: assert property (@(posedge core_clk) disable iff (rst)
        (pairLaneModeStrapOe || primaryPortPowerDownStrapOe
         || secondaryPortPowerDownStrapOe) |-> testMode)
        else $error("strap driver enabled outside test mode");
endmodule
`default_nettype wire

// ===== test/strap_board.sv
// board strap resistors for one port pair, overdriven by the device only in test mode
`timescale 1ns/100ps
`default_nettype none
module strap_board (
    // tie-off levels chosen for this board
    input  wire logic modeTie,
    input  wire logic priTie,
    input  wire logic secTie,
    // device drivers
    input  wire logic modeOut,
    input  wire logic modeOe,
    input  wire logic priOut,
    input  wire logic priOe,
    input  wire logic secOut,
    input  wire logic secOe,
    // resolved pin levels
    output logic      modePin,
    output logic      priPin,
    output logic      secPin
);
    // a 10k resistor always holds the pin; a device driver that is on wins over it
    assign modePin = modeOe ? modeOut : modeTie;
    assign priPin  = priOe ? priOut : priTie;
    assign secPin  = secOe ? secOut : secTie;
endmodule
`default_nettype wire

// ===== test/tb_top.sv
// self-checking bench for the port pair strap capture block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic        hardResetLow = 1'b0;
    logic        testMode = 1'b0;
    logic [2:0]  testStrapDrive = 3'h0;
    logic [3:0]  regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [31:0] regRdata;
    logic        modeTie = 1'b0, priTie = 1'b1, secTie = 1'b1;
    logic        modeOut, modeOe, priOut, priOe, secOut, secOe;
    logic        modePin, priPin, secPin;
    logic        pairSingleLane, portNEnable, portN1Enable, portNPowerDown, portN1PowerDown;
    logic        strapsCaptured;
    logic [3:0]  laneMacroPowerDown;
    int          n_mismatch = 0;
    int          n_compared = 0;

    always #4 core_clk = ~core_clk;

    strap_board board_u (.modeTie(modeTie), .priTie(priTie), .secTie(secTie),
        .modeOut(modeOut), .modeOe(modeOe), .priOut(priOut), .priOe(priOe),
        .secOut(secOut), .secOe(secOe), .modePin(modePin), .priPin(priPin), .secPin(secPin));

    port_pair_strap_config dut_u (.core_clk(core_clk), .rst(rst), .hardResetLow(hardResetLow),
        .testMode(testMode), .pairLaneModeStrapIn(modePin), .pairLaneModeStrapOut(modeOut),
        .pairLaneModeStrapOe(modeOe), .primaryPortPowerDownStrapIn(priPin),
        .primaryPortPowerDownStrapOut(priOut), .primaryPortPowerDownStrapOe(priOe),
        .secondaryPortPowerDownStrapIn(secPin), .secondaryPortPowerDownStrapOut(secOut),
        .secondaryPortPowerDownStrapOe(secOe), .testStrapDrive(testStrapDrive),
        .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
        .regRdata(regRdata), .pairSingleLane(pairSingleLane), .portNEnable(portNEnable),
        .portN1Enable(portN1Enable), .laneMacroPowerDown(laneMacroPowerDown),
        .portNPowerDown(portNPowerDown), .portN1PowerDown(portN1PowerDown),
        .strapsCaptured(strapsCaptured));

    ////////////////////////////////////////////////////////////////////////////////
    // reporting
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chkBit(input logic got, input logic exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // register port and reset helpers
    task automatic regWr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic regRd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        d = regRdata;
    endtask

    // pulse hard reset with given straps, then wait for the capture window to close;
    // with lateFlip the board turns every strap over once its ten hold cycles are up
    task automatic capture(input logic m, input logic p, input logic s, input bit lateFlip = 1'b0);
        int k;
        @(posedge core_clk);
        modeTie      <= m;
        priTie       <= p;
        secTie       <= s;
        hardResetLow <= 1'b0;
        repeat (4) @(posedge core_clk);
        hardResetLow <= 1'b1;
        if (lateFlip) begin
            repeat (10) @(posedge core_clk);
            modeTie <= ~m;
            priTie  <= ~p;
            secTie  <= ~s;
        end
        for (k = 0; k < 60 && strapsCaptured !== 1'b1; k++) @(posedge core_clk);
        if (k == 60) begin
            n_mismatch++;
            $display("BAD t=%0t capture never finished", $time);
            tally_and_finish();
        end
        repeat (3) @(posedge core_clk);
        #1;
    endtask

    // every config output except strapsCaptured against the effective mode and power-down levels
    task automatic chkOutputs(input logic m, input logic p, input logic s);
        chkBit(pairSingleLane, m, "single lane");
        chkBit(portNPowerDown, p, "port n pd");
        chkWord({28'h0, laneMacroPowerDown}, {28'h0, {4{p}}}, "lane pd");
        chkBit(portNEnable, ~p, "port n enable");
        chkBit(portN1PowerDown, p | s, "port n1 pd");
        chkBit(portN1Enable, m & ~(p | s), "port n1 enable");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic scnFourLane();
        capture(1'b0, 1'b0, 1'b1);
        chkOutputs(1'b0, 1'b0, 1'b1);
        @(posedge core_clk);
        modeTie <= 1'b1;
        priTie  <= 1'b1;
        secTie  <= 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        chkOutputs(1'b0, 1'b0, 1'b1);
        capture(1'b0, 1'b0, 1'b1, 1'b1);
        chkOutputs(1'b0, 1'b0, 1'b1);
    endtask

    task automatic scnSingleLane();
        for (int i = 0; i < 4; i++) begin
            capture(1'b1, i[1], i[0]);
            chkOutputs(1'b1, i[1], i[0]);
        end
    endtask

    task automatic scnOverride();
        logic [31:0] d;
        capture(1'b1, 1'b0, 1'b0);
        regRd(4'h4, d);
        chkWord(d, 32'h9, "status");
        regWr(4'h0, 32'h5);
        chkOutputs(1'b1, 1'b1, 1'b0);
        regWr(4'h0, 32'ha);
        chkOutputs(1'b1, 1'b0, 1'b1);
        regRd(4'h0, d);
        chkWord(d, 32'ha, "clksel");
        regWr(4'h4, 32'h0);
        regRd(4'h4, d);
        chkWord(d, 32'h29, "status read only");
        regWr(4'hc, 32'hf);
        regRd(4'hc, d);
        chkWord(d, 32'h0, "unmapped");
        regWr(4'h0, 32'h0);
        chkOutputs(1'b1, 1'b0, 1'b0);
        regWr(4'h0, 32'h5);
        capture(1'b1, 1'b0, 1'b0);
        chkOutputs(1'b1, 1'b0, 1'b0);
        regRd(4'h0, d);
        chkWord(d, 32'h0, "clksel after hard reset");
    endtask

    task automatic scnTestMode();
        chkWord({29'h0, modeOe, priOe, secOe}, 32'h0, "oe off");
        @(posedge core_clk);
        testMode       <= 1'b1;
        testStrapDrive <= 3'h5;
        @(posedge core_clk);
        #1;
        chkWord({29'h0, modeOe, priOe, secOe}, 32'h7, "oe on");
        chkWord({29'h0, modeOut, priOut, secOut}, 32'h5, "drive");
        repeat (3) @(posedge core_clk);
        #1;
        chkOutputs(1'b1, 1'b0, 1'b0);
        @(posedge core_clk);
        testMode <= 1'b0;
        @(posedge core_clk);
        #1;
        chkWord({29'h0, modeOe, priOe, secOe}, 32'h0, "oe off again");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        chkOutputs(1'b0, 1'b1, 1'b1);
        scnFourLane();
        scnSingleLane();
        scnOverride();
        scnTestMode();
        tally_and_finish();
    end
endmodule
`default_nettype wire
